// file: core/clock_ctrl_pkg.sv
package clock_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CLOCK_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] OFS_TONE_CONTROL_REG     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS           = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK             = 8'h0C;

  // Reset values
  localparam logic [7:0] RST_CLOCK_CONTROL_STATUS = 8'h00;
  localparam logic [1:0] RST_TONE_CONTROL_REG     = 2'h0;
  localparam logic [0:0] RST_IRQ                  = 1'h0;

  // Field positions in clock_control_status
  localparam int BIT_CLOCK_OUT_SELECT    = 7;
  localparam int BIT_CPU_PRESCALE_SEL_HI = 6;
  localparam int BIT_CPU_PRESCALE_SEL_LO = 5;
  localparam int BIT_SLOW_SELECT         = 4;
  localparam int BIT_TIME_BASE_SEL_HI    = 3;
  localparam int BIT_TIME_BASE_SEL_LO    = 2;
  localparam int BIT_TIME_BASE_IRQ_EN    = 1;
  localparam int BIT_TIME_BASE_IRQ_FLAG  = 0;

  // Time-base periods in halved oscillator cycles
  localparam int TB_PERIOD_0 = 16000;
  localparam int TB_PERIOD_1 = 32000;
  localparam int TB_PERIOD_2 = 80000;
  localparam int TB_PERIOD_3 = 200000;
  localparam int TB_WIDTH    = 18;

  // Tone frequencies at the reference halved oscillator clock
  localparam int OSC2_REF_HZ = 8000000;
  localparam int TONE_HZ_1   = 2000;
  localparam int TONE_HZ_2   = 1000;
  localparam int TONE_HZ_3   = 500;
  localparam int TONE_HALF_1 = OSC2_REF_HZ / (2 * TONE_HZ_1);
  localparam int TONE_HALF_2 = OSC2_REF_HZ / (2 * TONE_HZ_2);
  localparam int TONE_HALF_3 = OSC2_REF_HZ / (2 * TONE_HZ_3);
  localparam int TONE_WIDTH  = 14;

  // Prescaler
  localparam int PRE_WIDTH = 4;
  localparam logic [1:0] TONE_OFF = 2'h0;

  typedef enum {
    MODE_RUN,
    MODE_WAIT,
    MODE_ACTIVE_HALT,
    MODE_HALT
  } power_mode_t;

endpackage : clock_ctrl_pkg

// file: core/clock_ctrl_time_base.sv
`timescale 1ns/1ps
`default_nettype none

module clock_ctrl_time_base
  import clock_ctrl_pkg::*;
#(
  parameter int TB_PERIOD0 = TB_PERIOD_0,
  parameter int TB_PERIOD1 = TB_PERIOD_1,
  parameter int TB_PERIOD2 = TB_PERIOD_2,
  parameter int TB_PERIOD3 = TB_PERIOD_3,
  parameter int TONE_HALF1 = TONE_HALF_1,
  parameter int TONE_HALF2 = TONE_HALF_2,
  parameter int TONE_HALF3 = TONE_HALF_3
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // CPU and power control
  input  wire logic        HALT_REQ,
  input  wire logic        WAIT_REQ,
  input  wire logic        HALT_EXIT_WAKE,
  input  wire logic        GLOBAL_IRQ_MASK,
  output logic             CPU_CLK_EN,
  output logic [1:0]       POWER_MODE,
  output logic             TB_IRQ_REQ,
  // Pins
  output logic             CLK_OUT,
  output logic             CLK_OUT_ENABLE,
  output logic             TONE_OUT,
  output logic             TONE_ENABLE,
  // Interrupt
  output logic             IRQ
);

  logic [7:0]            ccs;
  logic [7:1]            ccs_ctrl;
  logic                  tb_flag;
  logic [1:0]            tone_select;
  logic [0:0]            irq_status;
  logic [0:0]            irq_mask;
  power_mode_t           mode;
  power_mode_t           next_mode;
  logic                  wr_access;
  logic                  rd_access;
  logic                  regs_live;
  logic                  mapped;
  logic                  tb_run;
  logic                  tb_event;
  logic [TB_WIDTH-1:0]   tb_cnt;
  logic [TB_WIDTH-1:0]   tb_limit;
  logic [1:0]            tb_sel_active;
  logic [PRE_WIDTH-1:0]  pre_cnt;
  logic [PRE_WIDTH-1:0]  pre_limit;
  logic [2:0]            pre_code;
  logic                  pre_tick;
  logic                  cpu_phase;
  logic [TONE_WIDTH-1:0] tone_cnt;
  logic [TONE_WIDTH-1:0] tone_limit;
  logic [1:0]            tone_active;
  logic                  clear_flag;

  // Prescaler end counts per slow division
  localparam logic [PRE_WIDTH-1:0] PRE_END_DIV2  = PRE_WIDTH'(1);
  localparam logic [PRE_WIDTH-1:0] PRE_END_DIV4  = PRE_WIDTH'(3);
  localparam logic [PRE_WIDTH-1:0] PRE_END_DIV8  = PRE_WIDTH'(7);
  localparam logic [PRE_WIDTH-1:0] PRE_END_DIV16 = PRE_WIDTH'(15);

  // Bus decode
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_access = PSEL && PENABLE && !PWRITE;
  assign mapped    = (PADDR == OFS_CLOCK_CONTROL_STATUS) ||
                     (PADDR == OFS_TONE_CONTROL_REG) ||
                     (PADDR == OFS_IRQ_STATUS) ||
                     (PADDR == OFS_IRQ_MASK);
  assign PREADY    = PSEL && PENABLE;
  assign PSLVERR   = PSEL && PENABLE && !mapped;

  // Register writes and the prescaler frozen in both halt modes
  assign regs_live = (mode == MODE_RUN) || (mode == MODE_WAIT);

  // Control/status writes; flag bit is hardware owned
  assign ccs = {ccs_ctrl, tb_flag};

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ccs_ctrl <= RST_CLOCK_CONTROL_STATUS[7:1];
    end else if (regs_live && wr_access &&
                 PADDR == OFS_CLOCK_CONTROL_STATUS) begin
      ccs_ctrl <= PWDATA[7:1];
    end
  end

  // Read clears only a flag that the read actually returned
  assign clear_flag = regs_live && rd_access &&
                      PADDR == OFS_CLOCK_CONTROL_STATUS &&
                      PRDATA[BIT_TIME_BASE_IRQ_FLAG];

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tb_flag <= RST_CLOCK_CONTROL_STATUS[0];
    end else if (tb_event) begin
      tb_flag <= 1'b1;
    end else if (clear_flag) begin
      tb_flag <= 1'b0;
    end
  end

  // Tone control register
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tone_select <= RST_TONE_CONTROL_REG;
    end else if (regs_live && wr_access &&
                 PADDR == OFS_TONE_CONTROL_REG) begin
      tone_select <= PWDATA[1:0];
    end
  end

  // Sticky event status, write one to clear, set wins
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_status <= RST_IRQ;
    end else if (tb_event) begin
      irq_status <= 1'b1;
    end else if (regs_live && wr_access && PADDR == OFS_IRQ_STATUS &&
                 PWDATA[0]) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_mask <= RST_IRQ;
    end else if (regs_live && wr_access && PADDR == OFS_IRQ_MASK) begin
      irq_mask <= PWDATA[0:0];
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // Read data captured in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFS_CLOCK_CONTROL_STATUS: PRDATA <= {24'h00_0000, ccs};
        OFS_TONE_CONTROL_REG:     PRDATA <= {30'h0000_0000, tone_select};
        OFS_IRQ_STATUS:           PRDATA <= {31'h0000_0000, irq_status};
        OFS_IRQ_MASK:             PRDATA <= {31'h0000_0000, irq_mask};
        default:                  PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Time base runs in every mode except full halt
  assign tb_run = (mode != MODE_HALT);

  always_comb begin
    case (tb_sel_active)
      2'h0:    tb_limit = TB_WIDTH'(TB_PERIOD0 - 1);
      2'h1:    tb_limit = TB_WIDTH'(TB_PERIOD1 - 1);
      2'h2:    tb_limit = TB_WIDTH'(TB_PERIOD2 - 1);
      default: tb_limit = TB_WIDTH'(TB_PERIOD3 - 1);
    endcase
  end

  assign tb_event = tb_run && (tb_cnt == tb_limit);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tb_cnt        <= '0;
      tb_sel_active <= 2'h0;
    end else if (tb_event) begin
      tb_cnt        <= '0;
      tb_sel_active <= ccs[BIT_TIME_BASE_SEL_HI:BIT_TIME_BASE_SEL_LO];
    end else if (tb_run) begin
      tb_cnt        <= tb_cnt + 1'b1;
    end
  end

  // CPU request and power mode control
  assign TB_IRQ_REQ = ccs[BIT_TIME_BASE_IRQ_FLAG] &&
                      ccs[BIT_TIME_BASE_IRQ_EN] && !GLOBAL_IRQ_MASK;

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_RUN: begin
        if (HALT_REQ) begin
          next_mode = ccs[BIT_TIME_BASE_IRQ_EN] ?
                      MODE_ACTIVE_HALT : MODE_HALT;
        end else if (WAIT_REQ) begin
          next_mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (TB_IRQ_REQ || HALT_EXIT_WAKE) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_ACTIVE_HALT: begin
        if (TB_IRQ_REQ || HALT_EXIT_WAKE) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_HALT: begin
        if (HALT_EXIT_WAKE) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  always_comb begin
    case (mode)
      MODE_RUN:         POWER_MODE = 2'h0;
      MODE_WAIT:        POWER_MODE = 2'h1;
      MODE_ACTIVE_HALT: POWER_MODE = 2'h2;
      default:          POWER_MODE = 2'h3;
    endcase
  end

  // CPU prescaler
  assign pre_code = {ccs[BIT_SLOW_SELECT],
                     ccs[BIT_CPU_PRESCALE_SEL_HI:BIT_CPU_PRESCALE_SEL_LO]};
  assign pre_tick = (pre_cnt == pre_limit);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pre_cnt   <= '0;
      pre_limit <= '0;
    end else if (regs_live) begin
      if (pre_tick) begin
        pre_cnt <= '0;
        case (pre_code)
          3'h4:    pre_limit <= PRE_END_DIV2;
          3'h5:    pre_limit <= PRE_END_DIV4;
          3'h6:    pre_limit <= PRE_END_DIV8;
          3'h7:    pre_limit <= PRE_END_DIV16;
          default: pre_limit <= '0;
        endcase
      end else begin
        pre_cnt <= pre_cnt + 1'b1;
      end
    end
  end

  assign CPU_CLK_EN = regs_live && pre_tick;

  // Clock out pin
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cpu_phase <= 1'b0;
    end else if (CPU_CLK_EN) begin
      cpu_phase <= !cpu_phase;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CLK_OUT <= 1'b0;
    end else if (ccs[BIT_CLOCK_OUT_SELECT] && regs_live) begin
      CLK_OUT <= cpu_phase;
    end else if (!ccs[BIT_CLOCK_OUT_SELECT]) begin
      CLK_OUT <= 1'b0;
    end
  end

  assign CLK_OUT_ENABLE = ccs[BIT_CLOCK_OUT_SELECT];

  // Tone generator, running in active-halt, frozen in halt
  always_comb begin
    case (tone_active)
      2'h1:    tone_limit = TONE_WIDTH'(TONE_HALF1 - 1);
      2'h2:    tone_limit = TONE_WIDTH'(TONE_HALF2 - 1);
      default: tone_limit = TONE_WIDTH'(TONE_HALF3 - 1);
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tone_cnt    <= '0;
      tone_active <= TONE_OFF;
      TONE_OUT    <= 1'b0;
    end else if (mode != MODE_HALT) begin
      if (tone_select == TONE_OFF) begin
        tone_cnt    <= '0;
        tone_active <= TONE_OFF;
        TONE_OUT    <= 1'b0;
      end else if (tone_active != tone_select) begin
        tone_cnt    <= '0;
        tone_active <= tone_select;
      end else if (tone_cnt == tone_limit) begin
        tone_cnt <= '0;
        TONE_OUT <= !TONE_OUT;
      end else begin
        tone_cnt <= tone_cnt + 1'b1;
      end
    end
  end

  assign TONE_ENABLE = (tone_select != TONE_OFF);

endmodule : clock_ctrl_time_base

`default_nettype wire

// file: verif/clock_ctrl_time_base_props.sv
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_time_base_props (
  // Watched ports
  input wire logic       CORE_CLK, RESET_N, PSEL, PENABLE, PREADY,
  input wire logic       PSLVERR, HALT_REQ, HALT_EXIT_WAKE, TB_IRQ_REQ,
  input wire logic       GLOBAL_IRQ_MASK, CPU_CLK_EN, CLK_OUT,
  input wire logic       CLK_OUT_ENABLE, TONE_OUT, TONE_ENABLE,
  input wire logic [1:0] POWER_MODE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_ready_access: assert property (PREADY == (PSEL && PENABLE))
    else $error("ready outside access");
  a_err_access: assert property (PSLVERR |-> PREADY)
    else $error("error outside access");
  a_mask_blocks: assert property (GLOBAL_IRQ_MASK |-> !TB_IRQ_REQ)
    else $error("request while masked");
  a_halted_clk: assert property (POWER_MODE[1] |-> !CPU_CLK_EN)
    else $error("cpu tick while halted");
  a_clkout_hold: assert property (
    POWER_MODE[1] [*2] |-> $stable(CLK_OUT))
    else $error("clock-out moved in halt");
  a_clkout_off: assert property (!CLK_OUT_ENABLE [*2] |-> !CLK_OUT)
    else $error("clock-out active while off");
  a_halt_entry: assert property (
    POWER_MODE == 2'h0 && HALT_REQ |=> POWER_MODE[1])
    else $error("no halt entry");
  a_halt_stays: assert property (
    POWER_MODE == 2'h3 && !HALT_EXIT_WAKE |=> POWER_MODE == 2'h3)
    else $error("left halt without wake");
  a_tb_wakes: assert property (
    POWER_MODE inside {2'h1, 2'h2} && TB_IRQ_REQ |=> POWER_MODE == 2'h0)
    else $error("time base did not wake");
  a_tone_quiet: assert property (
    $changed(TONE_OUT) |-> ($past(TONE_ENABLE) || !TONE_OUT))
    else $error("tone moved while off");
  c_wake: cover property (POWER_MODE == 2'h2 ##1 POWER_MODE == 2'h0);
  c_slverr: cover property (PSLVERR);
  c_tone: cover property (TONE_ENABLE && $changed(TONE_OUT));
endmodule : clock_ctrl_time_base_props
bind clock_ctrl_time_base clock_ctrl_time_base_props u_props (.CORE_CLK,
  .RESET_N, .PSEL, .PENABLE, .PREADY, .PSLVERR, .HALT_REQ, .HALT_EXIT_WAKE,
  .TB_IRQ_REQ, .GLOBAL_IRQ_MASK, .CPU_CLK_EN, .CLK_OUT, .CLK_OUT_ENABLE,
  .TONE_OUT, .TONE_ENABLE, .POWER_MODE);
`default_nettype wire

// file: verif/main_clock_rtc_beeper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module main_clock_rtc_beeper_tb;
  import clock_ctrl_pkg::*;
  localparam int P[4] = '{16, 32, 80, 200};
  localparam int H[4] = '{0, 4, 8, 16};
  localparam logic [7:0] CCS = OFS_CLOCK_CONTROL_STATUS;
  logic        CORE_CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic        HALT_REQ = 0, WAIT_REQ = 0, HALT_EXIT_WAKE = 0;
  logic        GLOBAL_IRQ_MASK = 0, PREADY, PSLVERR, CPU_CLK_EN, TB_IRQ_REQ;
  logic        CLK_OUT, CLK_OUT_ENABLE, TONE_OUT, TONE_ENABLE, IRQ, err, prev;
  logic [1:0]  POWER_MODE;
  logic [7:0]  PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  int          err_total = 0, comparisons = 0, n, e, t, cur;
  clock_ctrl_time_base #(.TB_PERIOD0(P[0]), .TB_PERIOD1(P[1]),
    .TB_PERIOD2(P[2]), .TB_PERIOD3(P[3]), .TONE_HALF1(H[1]),
    .TONE_HALF2(H[2]), .TONE_HALF3(H[3])) dut (.CORE_CLK, .RESET_N, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .HALT_REQ, .WAIT_REQ, .HALT_EXIT_WAKE, .GLOBAL_IRQ_MASK, .CPU_CLK_EN,
    .POWER_MODE, .TB_IRQ_REQ, .CLK_OUT, .CLK_OUT_ENABLE, .TONE_OUT,
    .TONE_ENABLE, .IRQ);
  initial begin
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input logic [31:0] g, x, input string m);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic bound();
    if (n >= 400) begin
      chk(0, 1, "wait timed out");
      finish_test();
    end
  endtask : bound
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 400);
    bound();
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : apb
  // Wait for irq (0), a power mode (1) or a tone edge (2)
  task automatic wt(input int s, logic [1:0] m);
    prev = TONE_OUT;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (!(s == 0 ? IRQ === 1'b1 : s == 1 ? POWER_MODE === m :
               TONE_OUT !== prev) && n < 400);
    bound();
  endtask : wt
  task automatic pl(input int s);
    HALT_REQ <= s == 0;
    WAIT_REQ <= s == 1;
    HALT_EXIT_WAKE <= s == 2;
    @(posedge CORE_CLK);
    HALT_REQ <= 1'b0;
    WAIT_REQ <= 1'b0;
    HALT_EXIT_WAKE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : pl
  task automatic t_reset();
    apb(0, CCS, 0);
    chk(rd, RST_CLOCK_CONTROL_STATUS, "ccs reset");
    apb(0, OFS_TONE_CONTROL_REG, 0);
    chk(rd, RST_TONE_CONTROL_REG, "tone reset");
    apb(0, 8'h10, 0);
    chk(err, 1, "unmapped error");
    chk(rd, 0, "unmapped read zero");
    $display("test reset done");
  endtask : t_reset
  task automatic t_pre();
    for (int c = 0; c < 5; c++) begin
      apb(1, CCS, c < 4 ? 32'h90 | c << 5 : 32'hE0);
      repeat (32) @(posedge CORE_CLK);
      e = 0;
      t = 0;
      prev = CLK_OUT;
      repeat (64) begin
        @(posedge CORE_CLK);
        e += CPU_CLK_EN;
        t += CLK_OUT !== prev;
        prev = CLK_OUT;
      end
      chk(e, c < 4 ? 32 >> c : 64, "cpu ticks");
      chk(t, c < 4 ? 32 >> c : 64, "clock-out edges");
    end
    chk(CLK_OUT_ENABLE, 1, "clock-out on");
    apb(1, CCS, 0);
    chk(CLK_OUT_ENABLE, 0, "clock-out off");
    $display("test prescaler done");
  endtask : t_pre
  task automatic t_tb();
    apb(1, OFS_IRQ_MASK, 1);
    apb(1, OFS_IRQ_STATUS, 1);
    wt(0, 0);
    cur = 0;
    for (int i = 1; i < 5; i++) begin
      apb(1, CCS, (i % 4) << 2);
      apb(1, OFS_IRQ_STATUS, 1);
      wt(0, 0);
      chk(n + 6, P[cur], "old period");
      apb(1, OFS_IRQ_STATUS, 1);
      wt(0, 0);
      chk(n + 3, P[i % 4], "new period");
      cur = i % 4;
    end
    apb(0, CCS, 0);
    chk(rd[0], 1, "flag set");
    apb(0, CCS, 0);
    chk(rd[0], 0, "flag read-cleared");
    apb(1, OFS_IRQ_MASK, 0);
    chk(IRQ, 0, "irq masked");
    apb(1, OFS_IRQ_MASK, 1);
    chk(IRQ, 1, "irq unmasked");
    $display("test time base done");
  endtask : t_tb
  task automatic t_pwr();
    GLOBAL_IRQ_MASK <= 1'b1;
    apb(1, CCS, 32'h82);
    apb(1, OFS_IRQ_STATUS, 1);
    wt(0, 0);
    chk(TB_IRQ_REQ, 0, "request masked");
    GLOBAL_IRQ_MASK <= 1'b0;
    @(posedge CORE_CLK);
    chk(TB_IRQ_REQ, 1, "request");
    apb(0, CCS, 0);
    pl(0);
    chk(POWER_MODE, 2, "active-halt");
    prev = CLK_OUT;
    repeat (4) @(posedge CORE_CLK);
    chk(CLK_OUT, prev, "clock-out held in active-halt");
    wt(1, 0);
    apb(0, CCS, 0);
    pl(1);
    chk(POWER_MODE, 1, "wait");
    wt(1, 0);
    apb(1, CCS, 0);
    pl(0);
    chk(POWER_MODE, 3, "halt");
    repeat (60) @(posedge CORE_CLK);
    chk(POWER_MODE, 3, "halt held");
    pl(2);
    chk(POWER_MODE, 0, "halt exit");
    $display("test power done");
  endtask : t_pwr
  task automatic t_tone();
    for (int c = 3; c >= 0; c--) begin
      apb(1, OFS_TONE_CONTROL_REG, c);
      chk(TONE_ENABLE, c != 0, "tone enable");
      if (c != 0) begin
        wt(2, 0);
        wt(2, 0);
        chk(n, H[c], "tone half period");
      end else begin
        @(posedge CORE_CLK);
        chk(TONE_OUT, 0, "tone low when off");
      end
    end
    $display("test tone done");
  endtask : t_tone
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    @(posedge CORE_CLK);
    t_reset();
    t_pre();
    t_tb();
    t_pwr();
    t_tone();
    finish_test();
  end
endmodule : main_clock_rtc_beeper_tb
`default_nettype wire
